// ---- general_purpose_port_logic.sv ----
// Per-axis and shared general-purpose pin logic with its registers.
`timescale 1ns/10ps
module general_purpose_port_logic #(
  parameter int AXES       = 1,
  parameter int AXIS_IDX_W = 2
) (
  input  wire logic                                        sys_clk_i,
  input  wire logic                                        reset_n_i,
  input  gpio_port_pkg::reg_sel_t                          reg_sel_i,
  input  wire logic [AXIS_IDX_W-1:0]                       axis_sel_i,
  input  wire logic                                        low_byte_write_strobe_i,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]            write_buffer_i,
  output logic      [gpio_port_pkg::DATA_W-1:0]            rd_data_o,
  input  wire logic                                        legacy_mode_i,
  input  wire logic [AXES-1:0]                             axis_func_sel_i,
  input  wire logic [AXES-1:0][gpio_port_pkg::AXIS_PINS-1:0] axis_pin_direction_bits_i,
  input  wire logic [AXES-1:0][gpio_port_pkg::AXIS_PINS-1:0] phase_sequence_outputs_i,
  input  wire logic [AXES-1:0][gpio_port_pkg::AXIS_PINS-1:0] axis_general_pins_i,
  output gpio_port_pkg::axis_drive_t [AXES-1:0]            axis_general_pins_o,
  input  wire logic [gpio_port_pkg::SHARED_PINS-1:0]       shared_general_pins_i,
  output gpio_port_pkg::shared_drive_t                     shared_general_pins_o
);
  import gpio_port_pkg::*;

  logic [AXES-1:0][AXIS_PINS-1:0] axis_sync1_q;
  logic [AXES-1:0][AXIS_PINS-1:0] axis_sync2_q;
  logic [SHARED_PINS-1:0]         shared_sync1_q;
  logic [SHARED_PINS-1:0]         shared_sync2_q;
  logic [AXES-1:0][AXIS_PINS-1:0] axis_level_q;
  logic [AXES-1:0][AXIS_PINS-1:0] axis_level_d;
  logic [SHARED_PINS-1:0]         shared_dir_q;
  logic [SHARED_PINS-1:0]         shared_dir_d;
  logic [SHARED_PINS-1:0]         shared_level_q;
  logic [SHARED_PINS-1:0]         shared_level_d;
  logic [DATA_W-1:0]              rd_data_q;
  logic [DATA_W-1:0]              rd_data_d;
  axis_drive_t [AXES-1:0]         axis_drive_q;
  axis_drive_t [AXES-1:0]         axis_drive_d;
  shared_drive_t                  shared_drive_q;
  shared_drive_t                  shared_drive_d;
  logic                           axis_sel_ok;
  logic                           axis_access;

  // Pin levels pass two flip-flops before anything reads them.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      axis_sync1_q   <= '0;
      axis_sync2_q   <= '0;
      shared_sync1_q <= '0;
      shared_sync2_q <= '0;
    end else begin
      axis_sync1_q   <= axis_general_pins_i;
      axis_sync2_q   <= axis_sync1_q;
      shared_sync1_q <= shared_general_pins_i;
      shared_sync2_q <= shared_sync1_q;
    end
  end

  // The axis port register is reachable only outside legacy mode and for an existing axis.
  assign axis_sel_ok = (int'(axis_sel_i) < AXES);
  assign axis_access = axis_sel_ok && !legacy_mode_i && (reg_sel_i == SEL_AXIS_PORT);

  // Register writes, read data and pin drive are computed here.
  always_comb begin
    axis_level_d   = axis_level_q;
    shared_dir_d   = shared_dir_q;
    shared_level_d = shared_level_q;
    rd_data_d      = READ_ZERO;
    if (low_byte_write_strobe_i) begin
      if (axis_access) begin
        axis_level_d[axis_sel_i] = write_buffer_i[AXIS_PINS-1:0];
      end else if (reg_sel_i == SEL_SHARED_DIR) begin
        shared_dir_d = write_buffer_i[SHARED_PINS-1:0];
      end else if (reg_sel_i == SEL_SHARED_LEVEL) begin
        shared_level_d = write_buffer_i[SHARED_PINS-1:0];
      end
    end
    if (axis_access) begin
      rd_data_d = {{(DATA_W-AXIS_PINS){1'b0}}, axis_sync2_q[axis_sel_i]};
    end else if (reg_sel_i == SEL_SHARED_LEVEL) begin
      rd_data_d = {{(DATA_W-SHARED_PINS){1'b0}}, shared_sync2_q};
    end
    for (int a = 0; a < AXES; a++) begin
      if (axis_func_sel_i[a] == FUNC_GENERAL && !legacy_mode_i) begin
        axis_drive_d[a].level  = axis_level_q[a];
        axis_drive_d[a].enable = ~axis_pin_direction_bits_i[a];
      end else begin
        axis_drive_d[a].level  = phase_sequence_outputs_i[a];
        axis_drive_d[a].enable = AXIS_ENABLE_RESET;
      end
    end
    shared_drive_d.level  = shared_level_q;
    shared_drive_d.enable = ~shared_dir_q;
  end

  // All state except the pin sync stages is registered here; one shared set exists however many axes there are.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      axis_level_q   <= {AXES{AXIS_LEVEL_RESET}};
      shared_dir_q   <= SHARED_DIR_RESET;
      shared_level_q <= SHARED_LEVEL_RESET;
      rd_data_q      <= READ_ZERO;
      for (int a = 0; a < AXES; a++) begin
        axis_drive_q[a] <= '{level: AXIS_LEVEL_RESET, enable: AXIS_ENABLE_RESET};
      end
      shared_drive_q <= '{level: SHARED_LEVEL_RESET, enable: ~SHARED_DIR_RESET};
    end else begin
      axis_level_q   <= axis_level_d;
      shared_dir_q   <= shared_dir_d;
      shared_level_q <= shared_level_d;
      rd_data_q      <= rd_data_d;
      axis_drive_q   <= axis_drive_d;
      shared_drive_q <= shared_drive_d;
    end
  end

  assign rd_data_o             = rd_data_q;
  assign axis_general_pins_o   = axis_drive_q;
  assign shared_general_pins_o = shared_drive_q;

  // Checks on the first axis and the shared group.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_axis_write;
    low_byte_write_strobe_i && reg_sel_i == SEL_AXIS_PORT && !legacy_mode_i && axis_sel_i == '0;
  endsequence
  sequence s_axis_general;
    axis_func_sel_i[0] && !legacy_mode_i;
  endsequence
  sequence s_shared_write;
    low_byte_write_strobe_i && reg_sel_i == SEL_SHARED_LEVEL;
  endsequence
  sequence s_dir_write;
    low_byte_write_strobe_i && reg_sel_i == SEL_SHARED_DIR;
  endsequence

  property p_phase_route;
    (!axis_func_sel_i[0] && !legacy_mode_i) |=>
      axis_general_pins_o[0].level == $past(phase_sequence_outputs_i[0]) && axis_general_pins_o[0].enable == 4'hF;
  endproperty
  a_phase_route: assert property (p_phase_route) else $error("phase outputs not routed to axis pins");

  property p_axis_dir;
    s_axis_general |=> axis_general_pins_o[0].enable == ~$past(axis_pin_direction_bits_i[0]);
  endproperty
  a_axis_dir: assert property (p_axis_dir) else $error("axis pin enable does not follow direction bits");

  property p_axis_read;
    (reg_sel_i == SEL_AXIS_PORT && !legacy_mode_i && axis_sel_i == '0) |=>
      rd_data_o == {4'h0, $past(axis_sync2_q[0])};
  endproperty
  a_axis_read: assert property (p_axis_read) else $error("axis port read does not show pin levels");

  property p_axis_write;
    s_axis_write ##1 s_axis_general |=> axis_general_pins_o[0].level == $past(write_buffer_i[3:0], 2);
  endproperty
  a_axis_write: assert property (p_axis_write) else $error("axis port write not driven on pins");

  property p_shared_dir;
    1'b1 |=> shared_general_pins_o.enable == ~$past(shared_dir_q);
  endproperty
  a_shared_dir: assert property (p_shared_dir) else $error("shared enable does not follow direction");

  property p_reset_state;
    $rose(reset_n_i) |-> shared_general_pins_o.enable == 6'h00 && shared_general_pins_o.level == 6'h00 &&
      axis_general_pins_o[0].enable == 4'hF && axis_level_q[0] == 4'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pin state wrong after reset");

  property p_shared_read;
    (reg_sel_i == SEL_SHARED_LEVEL) |=> rd_data_o[7:6] == 2'b00 && rd_data_o[5:0] == $past(shared_sync2_q);
  endproperty
  a_shared_read: assert property (p_shared_read) else $error("shared level read wrong");

  property p_shared_write;
    s_shared_write |=> ##1 shared_general_pins_o.level == $past(write_buffer_i[5:0], 2);
  endproperty
  a_shared_write: assert property (p_shared_write) else $error("shared level write not driven");

  property p_legacy;
    legacy_mode_i |=> axis_general_pins_o[0].enable == 4'hF && $stable(axis_level_q);
  endproperty
  a_legacy: assert property (p_legacy) else $error("axis port usable in legacy mode");

  // A direction write reaches the shared output enables one cycle after the latch.
  property p_shared_dir_write;
    s_dir_write |=> ##1 shared_general_pins_o.enable == ~$past(write_buffer_i[5:0], 2);
  endproperty
  a_shared_dir_write: assert property (p_shared_dir_write) else $error("shared direction write not applied");

  // Latches move only on a strobe aimed at them, so stale selections cannot disturb them.
  property p_axis_hold;
    !(low_byte_write_strobe_i && reg_sel_i == SEL_AXIS_PORT) |=> $stable(axis_level_q[0]);
  endproperty
  a_axis_hold: assert property (p_axis_hold) else $error("axis level latch changed without write");

  property p_shared_hold;
    !(low_byte_write_strobe_i && reg_sel_i == SEL_SHARED_LEVEL) |=> $stable(shared_level_q);
  endproperty
  a_shared_hold: assert property (p_shared_hold) else $error("shared level latch changed without write");

  property p_dir_hold;
    !(low_byte_write_strobe_i && reg_sel_i == SEL_SHARED_DIR) |=> $stable(shared_dir_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("shared direction changed without write");

  // Refused reads return zero.
  property p_legacy_read;
    (legacy_mode_i && reg_sel_i == SEL_AXIS_PORT) |=> rd_data_o == 8'h00;
  endproperty
  a_legacy_read: assert property (p_legacy_read) else $error("axis port readable in legacy mode");

  property p_dir_read;
    (reg_sel_i == SEL_SHARED_DIR) |=> rd_data_o == 8'h00;
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("shared direction read not zero");

  // Pin to read data takes three edges; the gate skips edges whose sync stages were still in reset.
  property p_shared_monitor;
    ($past(reset_n_i, 2) && reg_sel_i == SEL_SHARED_LEVEL) |=>
      rd_data_o[5:0] == $past(shared_general_pins_i, 3);
  endproperty
  a_shared_monitor: assert property (p_shared_monitor) else $error("shared monitor not showing pins");

  property p_axis_monitor;
    ($past(reset_n_i, 2) && reg_sel_i == SEL_AXIS_PORT && !legacy_mode_i && axis_sel_i == '0) |=>
      rd_data_o[3:0] == $past(axis_general_pins_i[0], 3);
  endproperty
  a_axis_monitor: assert property (p_axis_monitor) else $error("axis monitor not showing pins");

endmodule : general_purpose_port_logic

// ---- gpio_port_pkg.sv ----
// Constants, selection codes and pin carriers for the general-purpose port logic.
package gpio_port_pkg;

  localparam int          AXIS_PINS          = 4;
  localparam int          SHARED_PINS        = 6;
  localparam int          DATA_W             = 8;
  localparam logic        FUNC_PHASE         = 1'b0;
  localparam logic        FUNC_GENERAL       = 1'b1;
  localparam logic [3:0]  AXIS_LEVEL_RESET   = 4'h0;
  localparam logic [3:0]  AXIS_ENABLE_RESET  = 4'hF;
  localparam logic [5:0]  SHARED_LEVEL_RESET = 6'h00;
  localparam logic [5:0]  SHARED_DIR_RESET   = 6'h3F;
  localparam logic [7:0]  READ_ZERO          = 8'h00;

  // Register currently chosen by the register selection command.
  typedef enum logic [1:0] {
    SEL_OTHER,
    SEL_AXIS_PORT,
    SEL_SHARED_DIR,
    SEL_SHARED_LEVEL
  } reg_sel_t;

  // Output level and output enable of one axis pin group.
  typedef struct packed {
    logic [AXIS_PINS-1:0] level;
    logic [AXIS_PINS-1:0] enable;
  } axis_drive_t;

  // Output level and output enable of the shared pin group.
  typedef struct packed {
    logic [SHARED_PINS-1:0] level;
    logic [SHARED_PINS-1:0] enable;
  } shared_drive_t;

endpackage : gpio_port_pkg

// ---- ext_pins.sv ----
// Model of the outside circuitry wired to the axis and shared pins.
`timescale 1ns/10ps
module ext_pins (
  input  gpio_port_pkg::axis_drive_t   axis_drv_i,
  input  gpio_port_pkg::shared_drive_t shared_drv_i,
  input  wire logic [3:0]              axis_ext_i,
  input  wire logic [5:0]              shared_ext_i,
  output logic      [3:0]              axis_pin_o,
  output logic      [5:0]              shared_pin_o
);
  import gpio_port_pkg::*;
  // A pin follows the chip where it drives and the outside source elsewhere.
  always_comb begin
    axis_pin_o   = (axis_drv_i.enable & axis_drv_i.level) | (~axis_drv_i.enable & axis_ext_i);
    shared_pin_o = (shared_drv_i.enable & shared_drv_i.level) | (~shared_drv_i.enable & shared_ext_i);
  end
endmodule : ext_pins

// ---- tb_top.sv ----
// Self-checking bench for the general-purpose port logic.
`timescale 1ns/10ps
module tb_top;
  import gpio_port_pkg::*;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, strobe = 1'b0, legacy = 1'b0, func = 1'b0;
  logic [1:0] ax_sel = 2'h0;
  reg_sel_t sel = SEL_OTHER;
  logic [7:0] wbuf = 8'h00, rd;
  logic [3:0] a_dir = 4'hF, phase = 4'h0, a_ext = 4'h0, a_lat = 4'h0, a_pin, a_en;
  logic [5:0] s_dir = 6'h3F, s_lat = 6'h00, s_ext = 6'h00, s_pin;
  logic [15:0] lfsr_q = 16'hF38F, v;
  axis_drive_t [0:0] a_drv;
  shared_drive_t s_drv;
  int n_mismatch = 0, n_compared = 0;
  // Clock of 100 ns period.
  always #50 sys_clk_i = ~sys_clk_i;
  general_purpose_port_logic dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_sel_i(sel),
    .axis_sel_i(ax_sel), .low_byte_write_strobe_i(strobe), .write_buffer_i(wbuf), .rd_data_o(rd),
    .legacy_mode_i(legacy), .axis_func_sel_i(func), .axis_pin_direction_bits_i(a_dir),
    .phase_sequence_outputs_i(phase), .axis_general_pins_i(a_pin), .axis_general_pins_o(a_drv),
    .shared_general_pins_i(s_pin), .shared_general_pins_o(s_drv));
  ext_pins far (.axis_drv_i(a_drv[0]), .shared_drv_i(s_drv), .axis_ext_i(a_ext), .shared_ext_i(s_ext),
    .axis_pin_o(a_pin), .shared_pin_o(s_pin));
  // Draws sixteen fresh bits from the shift register.
  function automatic logic [15:0] rnd();
    for (int k = 0; k < 16; k++) lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd
  // Level a pin settles at, given its drive and the outside source.
  function automatic logic [5:0] pin_of(input logic [5:0] en, input logic [5:0] lv, input logic [5:0] ex);
    return (en & lv) | (~en & ex);
  endfunction : pin_of
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input reg_sel_t s, input logic [7:0] d);
    @(posedge sys_clk_i);
    sel <= s;
    strobe <= 1'b1;
    wbuf <= d;
    @(posedge sys_clk_i);
    strobe <= 1'b0;
  endtask : wr
  // Selects a register and waits past the pin sync and read stages.
  task automatic sel_read(input reg_sel_t s);
    @(posedge sys_clk_i);
    sel <= s;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : sel_read
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // Reset values, then random traffic with legacy and out-of-range corner cases.
  initial begin
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(rd, 12'h000);
    check(a_drv[0], 12'h00F);
    check(s_drv, 12'h000);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    s_ext <= 6'h2D;
    sel_read(SEL_SHARED_LEVEL);
    check(rd, 12'h02D);
    for (int i = 0; i < 48; i++) begin
      v = rnd();
      @(posedge sys_clk_i);
      func <= v[0];
      legacy <= (i % 8 == 7);
      ax_sel <= (i % 5 == 4) ? 2'h1 : 2'h0;
      a_dir <= v[7:4];
      phase <= v[11:8];
      a_ext <= v[15:12];
      s_ext <= v[13:8];
      v = rnd();
      wr(SEL_AXIS_PORT, v[7:0]);
      wr(SEL_SHARED_DIR, {2'h0, v[11:6]});
      wr(SEL_SHARED_LEVEL, v[15:8]);
      wr(SEL_OTHER, ~v[7:0]);
      if (!legacy && ax_sel == 2'h0) a_lat = v[3:0];
      s_dir = v[11:6];
      s_lat = v[13:8];
      sel_read(SEL_AXIS_PORT);
      a_en = (func && !legacy) ? ~a_dir : 4'hF;
      if (func && !legacy) check({a_drv[0].level & a_en, a_drv[0].enable}, {a_lat & a_en, a_en});
      else check(a_drv[0], {phase, 4'hF});
      if (legacy || ax_sel != 2'h0) check(rd, 12'h000);
      else check(rd, {6'h00, pin_of({2'h0, a_en}, {2'h0, (func ? a_lat : phase)}, {2'h0, a_ext})});
      sel_read(SEL_SHARED_LEVEL);
      check({s_drv.level & ~s_dir, s_drv.enable}, {s_lat & ~s_dir, ~s_dir});
      check(rd, {6'h00, pin_of(~s_dir, s_lat, s_ext)});
      sel_read(SEL_SHARED_DIR);
      check(rd, 12'h000);
    end
    // Mid-run reset: both level latches must come back low, seen on pins driven against the outside.
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    func      <= 1'b1;
    legacy    <= 1'b0;
    ax_sel    <= 2'h0;
    a_dir     <= 4'h0;
    a_ext     <= 4'hF;
    s_ext     <= 6'h3F;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check(a_drv[0], 12'h00F);
    check(s_drv, 12'h000);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    wr(SEL_SHARED_DIR, 8'h00);
    sel_read(SEL_AXIS_PORT);
    check(a_drv[0], 12'h00F);
    check(rd, 12'h000);
    sel_read(SEL_SHARED_LEVEL);
    check(s_drv, 12'h03F);
    check(rd, 12'h000);
    stop_test();
  end
endmodule : tb_top
